/* wol_pkg.sv */
// constants and types for the power-on wake standby controller
package wol_pkg;
   localparam int FLAG_W = 16;
   localparam int FLAG_IND_BIT = 15;
   localparam int FLAG_TYP_BIT = 14;
   localparam int FLAG_POL_BIT = 13;
   localparam int FLAG_PIN_BIT = 12;
   localparam int FLAG_SELF_BIT = 0;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam int CLK_PERIOD_NS = 100;
   localparam int PULSE_TIME_NS = 1000;
   localparam int PULSE_CYCLES = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_W = 8;
   localparam logic [7:0] PULSE_LOAD = PULSE_CYCLES[7:0];
   localparam logic [7:0] SYNC_BYTE = 8'hff;
   localparam logic [2:0] SYNC_COUNT = 3'h6;
   localparam logic [2:0] MAC_LAST = 3'h5;
   localparam logic [4:0] MAC_REPEATS = 5'h10;
   typedef enum logic [1:0] {st_boot, st_standby, st_normal} wake_state_t;
   typedef enum logic [1:0] {ph_hunt, ph_mac, ph_found} scan_phase_t;
endpackage

/* wake_if.sv */
// receive byte stream and match result between controller and packet detector
`timescale 1ns/1ps
`default_nettype none
interface wake_if;
   logic ce;
   logic arm;
   logic [47:0] mac;
   logic [7:0] rx_byte;
   logic rx_valid;
   logic rx_start;
   logic rx_end;
   logic rx_good;
   logic match;
   modport ctrl (output ce, arm, mac, rx_byte, rx_valid, rx_start, rx_end, rx_good,
                 input match);
   modport det (input ce, arm, mac, rx_byte, rx_valid, rx_start, rx_end, rx_good,
                output match);
endinterface
`default_nettype wire

/* wake_packet_detector.sv */
// wake packet detector: sync bytes followed by repeated station address
`timescale 1ns/1ps
`default_nettype none
module wake_packet_detector (
   input wire logic clk_in,
   input wire logic reset_in,
   wake_if.det bus
);
   wol_pkg::scan_phase_t phase, next_phase;
   logic [2:0] ff_cnt, next_ff_cnt;
   logic [2:0] mac_idx, next_mac_idx;
   logic [4:0] rep_cnt, next_rep_cnt;
   logic match, next_match;

   // first byte on the wire is the top byte of the address
   function automatic logic [7:0] mac_byte(input logic [47:0] mac, input logic [2:0] idx);
      return mac[(47 - 8 * idx) -: 8];
   endfunction

   always_comb begin
      next_phase = phase;
      next_ff_cnt = ff_cnt;
      next_mac_idx = mac_idx;
      next_rep_cnt = rep_cnt;
      // a match held through a freeze is still taken once enable returns
      next_match = match;
      if (bus.ce) begin
         next_match = 1'b0;
         if (!bus.arm || bus.rx_start) begin
            next_phase = wol_pkg::ph_hunt;
            next_ff_cnt = 3'h0;
            next_mac_idx = 3'h0;
            next_rep_cnt = 5'h0;
         end
         if (bus.arm && bus.rx_valid) begin
            unique case (next_phase)
               wol_pkg::ph_hunt: begin
                  if (bus.rx_byte == wol_pkg::SYNC_BYTE) begin
                     if (next_ff_cnt != wol_pkg::SYNC_COUNT) begin
                        next_ff_cnt = next_ff_cnt + 3'h1;
                     end
                  end else if (next_ff_cnt == wol_pkg::SYNC_COUNT &&
                               bus.rx_byte == mac_byte(bus.mac, 3'h0)) begin
                     next_phase = wol_pkg::ph_mac;
                     next_mac_idx = 3'h1;
                     next_rep_cnt = 5'h0;
                  end else begin
                     next_ff_cnt = 3'h0;
                  end
               end
               wol_pkg::ph_mac: begin
                  if (bus.rx_byte == mac_byte(bus.mac, next_mac_idx)) begin
                     if (next_mac_idx == wol_pkg::MAC_LAST) begin
                        next_mac_idx = 3'h0;
                        next_rep_cnt = next_rep_cnt + 5'h1;
                        if (next_rep_cnt == wol_pkg::MAC_REPEATS) begin
                           next_phase = wol_pkg::ph_found;
                        end
                     end else begin
                        next_mac_idx = next_mac_idx + 3'h1;
                     end
                  end else begin
                     // a broken copy restarts the hunt; an ff here may open a new sync run
                     next_phase = wol_pkg::ph_hunt;
                     next_mac_idx = 3'h0;
                     next_rep_cnt = 5'h0;
                     next_ff_cnt = (bus.rx_byte == wol_pkg::SYNC_BYTE) ? 3'h1 : 3'h0;
                  end
               end
               wol_pkg::ph_found: begin
               end
               default: begin
                  next_phase = wol_pkg::ph_hunt;
               end
            endcase
         end
         if (bus.arm && bus.rx_end) begin
            // only a frame that ends good counts
            next_match = bus.rx_good && next_phase == wol_pkg::ph_found;
            next_phase = wol_pkg::ph_hunt;
            next_ff_cnt = 3'h0;
            next_mac_idx = 3'h0;
            next_rep_cnt = 5'h0;
         end
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         phase <= wol_pkg::ph_hunt;
         ff_cnt <= 3'h0;
         mac_idx <= 3'h0;
         rep_cnt <= 5'h0;
         match <= 1'b0;
      end else begin
         phase <= next_phase;
         ff_cnt <= next_ff_cnt;
         mac_idx <= next_mac_idx;
         rep_cnt <= next_rep_cnt;
         match <= next_match;
      end
   end

   assign bus.match = match;

   packet_match_a: assert property (@(posedge clk_in) disable iff (reset_in)
      match && $past(bus.ce) |-> $past(bus.rx_good) && $past(bus.rx_end) &&
                ($past(phase) == wol_pkg::ph_found ||
                 ($past(phase) == wol_pkg::ph_mac && $past(rep_cnt) == 5'hf)))
      else $error("wake match without sixteen address copies");
   full_match_c: cover property (@(posedge clk_in) disable iff (reset_in) match);
endmodule
`default_nettype wire

/* wol_standby_ctrl.sv */
// power-on wake standby controller top
`timescale 1ns/1ps
`default_nettype none
module wol_standby_ctrl (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic enable_in,
   input wire logic wake_strap_in,
   input wire logic [15:0] config_flag_in,
   input wire logic phy_mode_in,
   input wire logic secondary_link_up_in,
   input wire logic external_wake_low_in,
   input wire logic [47:0] station_mac_in,
   input wire logic [7:0] rx_byte_in,
   input wire logic rx_valid_in,
   input wire logic rx_start_in,
   input wire logic rx_end_in,
   input wire logic rx_good_in,
   input wire logic [1:0] usb_line_drive_in,
   input wire logic usb_line_oe_req_in,
   input wire logic [1:0] usb_differential_lines_in,
   output logic [1:0] usb_differential_lines_out,
   output logic usb_differential_lines_oe_out,
   output logic [1:0] usb_line_rx_out,
   output logic standby_out,
   output logic usb_transceiver_power_out,
   output logic usb_enable_out,
   output logic phy_power_out,
   output logic phy_autoneg_out,
   output logic power_event_output_out,
   output logic power_event_output_oe_out
);
   wake_if wif ();

   wol_pkg::wake_state_t state, next_state;
   logic [15:0] cfg, next_cfg;
   logic pe_active, next_pe_active;
   logic [7:0] pulse_cnt, next_pulse_cnt;
   logic wake_event;
   logic pe_asserted;
   logic pe_level;

   assign wif.ce = enable_in;
   assign wif.arm = state == wol_pkg::st_standby;
   assign wif.mac = station_mac_in;
   assign wif.rx_byte = rx_byte_in;
   assign wif.rx_valid = rx_valid_in;
   assign wif.rx_start = rx_start_in;
   assign wif.rx_end = rx_end_in;
   assign wif.rx_good = rx_good_in;

   wake_packet_detector detector (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .bus(wif.det)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // standby state machine

   // inputs are synchronous, so they feed the wake decision directly
   always_comb begin
      wake_event = wif.match
         || (phy_mode_in && secondary_link_up_in)
         || !external_wake_low_in;
   end

   always_comb begin
      next_state = state;
      next_cfg = cfg;
      next_pe_active = pe_active;
      next_pulse_cnt = pulse_cnt;
      if (enable_in) begin
         if (pulse_cnt != 8'h00) begin
            next_pulse_cnt = pulse_cnt - 8'h01;
         end
         unique case (state)
            // strap and flags are caught at the first enabled edge after release
            wol_pkg::st_boot: begin
               next_cfg = config_flag_in;
               if (wake_strap_in && config_flag_in[wol_pkg::FLAG_PIN_BIT]) begin
                  next_state = wol_pkg::st_standby;
               end else begin
                  next_state = wol_pkg::st_normal;
               end
            end
            wol_pkg::st_standby: begin
               if (wake_event) begin
                  next_pe_active = 1'b1;
                  next_pulse_cnt = wol_pkg::PULSE_LOAD;
                  next_state = wol_pkg::st_normal;
               end
            end
            wol_pkg::st_normal: begin
            end
            default: begin
               next_state = wol_pkg::st_boot;
            end
         endcase
      end
   end

   // pe_active only falls through reset, which gives the static hold
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state <= wol_pkg::st_boot;
         cfg <= wol_pkg::CFG_RESET;
         pe_active <= 1'b0;
         pulse_cnt <= 8'h00;
      end else begin
         state <= next_state;
         cfg <= next_cfg;
         pe_active <= next_pe_active;
         pulse_cnt <= next_pulse_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registered outputs

   logic next_standby, next_usb_power, next_usb_enable, next_phy_power;
   logic next_pe_out, next_pe_oe, next_usb_oe;
   logic [1:0] next_usb_out, next_usb_rx;

   always_comb begin
      // indication bit low means static level, high means a timed pulse
      if (next_cfg[wol_pkg::FLAG_IND_BIT]) begin
         pe_asserted = next_pulse_cnt != 8'h00;
      end else begin
         pe_asserted = next_pe_active;
      end
      pe_level = pe_asserted ? next_cfg[wol_pkg::FLAG_POL_BIT] :
                               !next_cfg[wol_pkg::FLAG_POL_BIT];
      next_standby = next_state == wol_pkg::st_standby;
      next_usb_enable = next_state == wol_pkg::st_normal;
      next_usb_power = next_state == wol_pkg::st_normal;
      next_phy_power = next_state != wol_pkg::st_boot;
      next_usb_oe = next_usb_enable && usb_line_oe_req_in;
      next_usb_out = next_usb_oe ? usb_line_drive_in : 2'h0;
      next_usb_rx = next_usb_enable ? usb_differential_lines_in : 2'h0;
      // pad path follows live inputs, so hold it too while frozen
      if (!enable_in) begin
         next_usb_oe = usb_differential_lines_oe_out;
         next_usb_out = usb_differential_lines_out;
         next_usb_rx = usb_line_rx_out;
      end
      next_pe_out = 1'b0;
      next_pe_oe = 1'b0;
      if (next_state != wol_pkg::st_boot && next_cfg[wol_pkg::FLAG_PIN_BIT]) begin
         next_pe_out = pe_level;
         // output type low: open drain, drive only the low level
         next_pe_oe = next_cfg[wol_pkg::FLAG_TYP_BIT] || !pe_level;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         standby_out <= 1'b0;
         usb_enable_out <= 1'b0;
         usb_transceiver_power_out <= 1'b0;
         phy_power_out <= 1'b0;
         phy_autoneg_out <= 1'b0;
         usb_differential_lines_oe_out <= 1'b0;
         usb_differential_lines_out <= 2'h0;
         usb_line_rx_out <= 2'h0;
         power_event_output_out <= 1'b0;
         power_event_output_oe_out <= 1'b0;
      end else begin
         standby_out <= next_standby;
         usb_enable_out <= next_usb_enable;
         usb_transceiver_power_out <= next_usb_power;
         phy_power_out <= next_phy_power;
         phy_autoneg_out <= next_phy_power;
         usb_differential_lines_oe_out <= next_usb_oe;
         usb_differential_lines_out <= next_usb_out;
         usb_line_rx_out <= next_usb_rx;
         power_event_output_out <= next_pe_out;
         power_event_output_oe_out <= next_pe_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   standby_entry_a: assert property (
      state == wol_pkg::st_boot && enable_in |=>
         standby_out == $past(wake_strap_in && config_flag_in[wol_pkg::FLAG_PIN_BIT]))
      else $error("standby entry does not follow strap and flag");
   normal_entry_a: assert property (
      state == wol_pkg::st_boot && enable_in && !wake_strap_in |=>
         usb_enable_out && !standby_out)
      else $error("low strap did not start normal mode");
   standby_power_a: assert property (
      standby_out |-> phy_power_out && phy_autoneg_out && !usb_transceiver_power_out &&
                      wif.arm)
      else $error("standby power domains wrong");
   usb_tristate_a: assert property (
      standby_out |-> !usb_differential_lines_oe_out && usb_differential_lines_out == 2'h0)
      else $error("usb lines driven in standby");
   packet_wake_a: assert property (
      state == wol_pkg::st_standby && enable_in && wif.match |=> pe_active && usb_enable_out)
      else $error("wake packet did not raise power event");
   link_wake_a: assert property (
      state == wol_pkg::st_standby && enable_in && phy_mode_in && secondary_link_up_in
         |=> pe_active && !standby_out)
      else $error("secondary link-up did not wake");
   pin_wake_a: assert property (
      state == wol_pkg::st_standby && enable_in && !external_wake_low_in |=> pe_active)
      else $error("external wake pin ignored");
   static_hold_a: assert property (
      pe_active && !cfg[wol_pkg::FLAG_IND_BIT] && cfg[wol_pkg::FLAG_PIN_BIT] |->
         power_event_output_out == cfg[wol_pkg::FLAG_POL_BIT] ##1 pe_active [*2])
      else $error("static power event dropped before reset");
   resume_usb_a: assert property (
      $rose(pe_active) |-> usb_enable_out && usb_transceiver_power_out && !standby_out)
      else $error("usb not restarted after power event");

   standby_c: cover property (state == wol_pkg::st_boot ##1 standby_out);
   pin_wake_c: cover property (standby_out && !external_wake_low_in ##1 pe_active);
   link_wake_c: cover property (standby_out && phy_mode_in && secondary_link_up_in);
endmodule
`default_nettype wire

/* pmic_host_model.sv */
// power management and host side model: config source, wake pin load, usb pads
`timescale 1ns/1ps
`default_nettype none
module pmic_host_model (
   input wire logic clk_in,
   input wire logic pulse_mode_in,
   input wire logic pin_select_in,
   input wire logic power_event_in,
   input wire logic power_event_oe_in,
   input wire logic [1:0] usb_lines_in,
   input wire logic usb_lines_oe_in,
   output logic [15:0] config_flag_out,
   output logic system_power_out,
   output logic [1:0] usb_pads_out
);
   logic [1:0] wobble = 2'h1;
   ////////////////////////////////////////
   // static or pulse, push-pull, active high, pin select, self-powered
   assign config_flag_out = {pulse_mode_in, 2'h3, pin_select_in, 11'h000, 1'b1};
   // weak pull-down on the pin, so an undriven pin never powers the system
   assign system_power_out = power_event_oe_in ? power_event_in : 1'b0;
   ////////////////////////////////////////
   // released pads show a changing pattern rather than a held value
   always @(posedge clk_in) begin
      wobble <= ~wobble;
   end
   assign usb_pads_out = usb_lines_oe_in ? usb_lines_in : wobble;
endmodule
`default_nettype wire

/* wol_standby_ctrl_bench.sv */
// self-checking bench for the power-on wake standby controller
`timescale 1ns/1ps
`default_nettype none
module wol_standby_ctrl_bench;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic enable_in = 1'b1;
   logic strap = 1'b0;
   logic pulse_mode = 1'b0;
   logic pin_sel = 1'b1;
   logic phy_mode = 1'b0;
   logic link_up = 1'b0;
   logic wake_low = 1'b1;
   logic [7:0] rx_byte = 8'h00;
   logic rx_valid = 1'b0;
   logic rx_start = 1'b0;
   logic rx_end = 1'b0;
   logic rx_good = 1'b0;
   logic [1:0] drive = 2'h2;
   logic oe_req = 1'b1;
   logic [47:0] mac = 48'h02a5c31e7f90;
   logic [15:0] flags;
   logic [1:0] pads, lines, line_rx;
   logic lines_oe, standby, xcvr, usb_en, phy_pwr, autoneg, pe, pe_oe, sys_on;
   int errors = 0;
   int check_count = 0;
   ////////////////////////////////////////
   wol_standby_ctrl uut (.clk_in(clk_in), .reset_in(reset_in), .enable_in(enable_in),
      .wake_strap_in(strap), .config_flag_in(flags), .phy_mode_in(phy_mode),
      .secondary_link_up_in(link_up), .external_wake_low_in(wake_low),
      .station_mac_in(mac), .rx_byte_in(rx_byte), .rx_valid_in(rx_valid),
      .rx_start_in(rx_start), .rx_end_in(rx_end), .rx_good_in(rx_good),
      .usb_line_drive_in(drive), .usb_line_oe_req_in(oe_req),
      .usb_differential_lines_in(pads), .usb_differential_lines_out(lines),
      .usb_differential_lines_oe_out(lines_oe), .usb_line_rx_out(line_rx),
      .standby_out(standby), .usb_transceiver_power_out(xcvr), .usb_enable_out(usb_en),
      .phy_power_out(phy_pwr), .phy_autoneg_out(autoneg),
      .power_event_output_out(pe), .power_event_output_oe_out(pe_oe));
   pmic_host_model partner (.clk_in(clk_in), .pulse_mode_in(pulse_mode),
      .pin_select_in(pin_sel), .power_event_in(pe), .power_event_oe_in(pe_oe),
      .usb_lines_in(lines), .usb_lines_oe_in(lines_oe), .config_flag_out(flags),
      .system_power_out(sys_on), .usb_pads_out(pads));
   initial begin
      forever #50 clk_in = ~clk_in;
   end
   ////////////////////////////////////////
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // returns at the falling edge just after the first enabled edge
   task automatic boot(input logic s, input logic p, input logic pm);
      @(negedge clk_in);
      reset_in = 1'b1;
      strap = s;
      pin_sel = p;
      pulse_mode = pm;
      wake_low = 1'b1;
      link_up = 1'b0;
      phy_mode = 1'b0;
      repeat (10) @(negedge clk_in);
      reset_in = 1'b0;
      @(negedge clk_in);
   endtask
   task automatic check_standby();
      check("standby", standby, 1'b1);
      check("xcvr_off", {xcvr, usb_en}, 2'h0);
      check("phy_on", {phy_pwr, autoneg}, 2'h3);
      check("pads_off", {lines_oe, lines, line_rx}, 5'h00);
      check("pe_idle", {pe, pe_oe}, 2'h1);
   endtask
   task automatic check_woken();
      check("pe_on", {pe, pe_oe, sys_on}, 3'h7);
      check("normal", {standby, usb_en, xcvr}, 3'h3);
      @(negedge clk_in);
      check("pads_on", {lines_oe, lines, line_rx}, 5'h1a);
   endtask
   task automatic pin_pulse();
      wake_low = 1'b0;
      @(negedge clk_in);
      wake_low = 1'b1;
   endtask
   task automatic send_frame(input logic good, input int reps);
      for (int i = 0; i < 6 + 6 * reps; i++) begin
         rx_start = (i == 0);
         rx_valid = 1'b1;
         rx_byte = (i < 6) ? 8'hff : mac[47 - 8 * ((i - 6) % 6) -: 8];
         @(negedge clk_in);
      end
      rx_start = 1'b0;
      rx_valid = 1'b0;
      rx_end = 1'b1;
      rx_good = good;
      @(negedge clk_in);
      rx_end = 1'b0;
      rx_good = 1'b0;
   endtask
   ////////////////////////////////////////
   task automatic s_normal();
      boot(1'b0, 1'b1, 1'b0);
      check("strap_low", {standby, usb_en, xcvr}, 3'h3);
      pin_pulse();
      check("no_wake", pe, 1'b0);
      oe_req = 1'b0;
      @(negedge clk_in);
      check("oe_refused", {lines_oe, lines}, 3'h0);
      oe_req = 1'b1;
   endtask
   task automatic s_no_pin();
      boot(1'b1, 1'b0, 1'b0);
      check("pin_unsel", {standby, usb_en}, 2'h1);
   endtask
   task automatic s_pin_wake();
      boot(1'b1, 1'b1, 1'b0);
      check_standby();
      pin_pulse();
      check_woken();
      repeat (50) @(negedge clk_in);
      check("pe_held", {pe, standby}, 2'h2);
      boot(1'b1, 1'b1, 1'b0);
      check_standby();
   endtask
   task automatic s_link();
      boot(1'b1, 1'b1, 1'b0);
      link_up = 1'b1;
      repeat (3) @(negedge clk_in);
      check("link_no_phy", standby, 1'b1);
      enable_in = 1'b0;
      phy_mode = 1'b1;
      repeat (3) @(negedge clk_in);
      check("frozen", standby, 1'b1);
      enable_in = 1'b1;
      @(negedge clk_in);
      check_woken();
   endtask
   task automatic s_packet();
      boot(1'b1, 1'b1, 1'b0);
      repeat (2) @(negedge clk_in);
      send_frame(1'b0, 16);
      send_frame(1'b1, 15);
      repeat (2) @(negedge clk_in);
      check("bad_frames", standby, 1'b1);
      send_frame(1'b1, 16);
      check("match_lag", standby, 1'b1);
      @(negedge clk_in);
      check_woken();
   endtask
   task automatic s_pulse();
      int n;
      boot(1'b1, 1'b1, 1'b1);
      check_standby();
      pin_pulse();
      n = 0;
      for (int i = 0; i < 20; i++) begin
         if (pe === 1'b1) begin
            n++;
         end
         @(negedge clk_in);
      end
      check("pulse_len", n[15:0], wol_pkg::PULSE_CYCLES[15:0]);
      check("pulse_normal", standby, 1'b0);
   endtask
   ////////////////////////////////////////
   // hang guard far above the run's own length
   initial begin
      #(100 * 30000);
      errors++;
      final_report();
   end
   initial begin
      s_normal();
      s_no_pin();
      s_pin_wake();
      s_link();
      s_packet();
      s_pulse();
      final_report();
   end
endmodule
`default_nettype wire
